// File: core/can_buf_pkg.sv
// Shared constants, register map and types for the CAN message buffer manager.
package can_buf_pkg;

  localparam int NUM_TX        = 3;
  localparam int TX_MSG_BYTES  = 13;
  localparam int TX_BUF_BYTES  = 16;
  localparam int RX_BUF_BYTES  = 15;
  localparam int RX_FIFO_DEPTH = 5;
  localparam int TIMER_W       = 16;

  // Byte positions inside one transmit buffer (message, priority, stamp).
  localparam logic [3:0] PRI_IDX     = 4'hd;
  localparam logic [3:0] TX_STAMP_HI = 4'he;
  localparam logic [3:0] TX_STAMP_LO = 4'hf;
  // Byte positions of the stamp inside one receive buffer.
  localparam logic [3:0] RX_STAMP_HI = 4'hd;
  localparam logic [3:0] RX_STAMP_LO = 4'he;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] TX_FLAG_ADDR   = 8'h01;
  localparam logic [7:0] TX_IRQ_EN_ADDR = 8'h02;
  localparam logic [7:0] ABORT_REQ_ADDR = 8'h03;
  localparam logic [7:0] ABORT_ACK_ADDR = 8'h04;
  localparam logic [7:0] TX_SEL_ADDR    = 8'h05;
  localparam logic [7:0] RX_FLAG_ADDR   = 8'h06;
  localparam logic [7:0] RX_IRQ_EN_ADDR = 8'h07;
  localparam logic [7:0] TX_WIN_ADDR    = 8'h10;
  localparam logic [7:0] RX_WIN_ADDR    = 8'h20;

  // Bit positions in the receive flag and receive interrupt enable registers.
  localparam int FULL_BIT = 0;
  localparam int OVR_BIT  = 1;

  localparam logic [7:0] CTRL_RESET      = 8'h01;
  localparam logic [7:0] TX_IRQ_EN_RESET = 8'h00;
  localparam logic [7:0] RX_IRQ_EN_RESET = 8'h00;

  typedef struct packed {
    logic [4:0] spare;
    logic       stamp_en;
    logic       loopback;
    logic       init_mode;
  } ctrl_s;

  typedef enum logic [0:0] {
    TX_IDLE,
    TX_ACTIVE
  } tx_state_e;

endpackage

// File: core/can_message_buffer_manager.sv
// Transmit buffers, receive FIFO and time stamping for a CAN controller.
// Contract
// [RULE1] With stamping on, write timer into active tx or rx buffer at acknowledge.
// [RULE2] Stamp timer runs free on bit clock ticks and wraps silently.
// [RULE3] Stamp timer is held at zero during initialization mode.
// [RULE4] Stamp bytes are read only; tx stamp readable once buffer flagged empty.
// [RULE5] Exactly three independent transmit buffers.
// [RULE6] Each tx buffer: 13 message bytes, one priority byte, two stamp bytes.
// [RULE7] Software selects an empty buffer; it appears in the single tx window.
// [RULE8] Software fills the buffer then clears its empty flag to queue it.
// [RULE9] Successful send sets empty flag; unmasked flag raises transmit interrupt.
// [RULE10] At arbitration the pending buffer with lowest priority value goes first.
// [RULE11] Prioritisation reruns on every arbitration, retries included.
// [RULE12] Abort request cancels a pending buffer, never one already sending.
// [RULE13] Granted abort sets ack, then empty flag, then interrupt; ack zero if sent. The code sets all three on the same edge.
// [RULE14] Five-stage receive FIFO; background device-only, foreground CPU-visible.
// [RULE15] Each receive buffer holds 15 bytes including optional stamp.
// [RULE16] Receive full flag set while foreground holds an accepted message.
// [RULE17] Filter during reception; valid frame shifts in, flags, interrupts.
// [RULE18] Software reads foreground then clears receive full flag to release it.
// [RULE19] Invalid or rejected frames are not shifted and get overwritten.
// [RULE20] Own frames are captured but not shifted, interrupted or acknowledged.
// [RULE21] Loopback treats own frames exactly like received frames.
// [RULE22] Full FIFO discards accepted frame, flags overrun; transmit continues.
// [RULE23] Equal lowest priorities resolve to the lowest buffer index.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

module can_message_buffer_manager #(
  parameter int RX_DEPTH = can_buf_pkg::RX_FIFO_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       bit_tick,
  input  wire logic       arb_start,
  input  wire logic       tx_done,
  input  wire logic       tx_fail,
  input  wire logic [3:0] tx_byte_idx,
  output logic      [7:0] tx_byte,
  output logic      [1:0] tx_buf_idx,
  output logic            tx_pending,
  output logic            tx_busy,
  input  wire logic       rx_byte_valid,
  input  wire logic [3:0] rx_byte_idx,
  input  wire logic [7:0] rx_byte_data,
  input  wire logic       rx_frame_ok,
  input  wire logic       rx_id_accept,
  output logic            rx_ack_enable,
  output logic            tx_irq,
  output logic            rx_irq,
  output logic            ovr_irq
);

  localparam int NT = can_buf_pkg::NUM_TX;
  localparam int PW = $clog2(RX_DEPTH);

  typedef logic [7:0] tx_buf_t [can_buf_pkg::TX_BUF_BYTES];
  typedef logic [7:0] rx_buf_t [can_buf_pkg::RX_BUF_BYTES];

  // Lowest priority value wins; the strict compare keeps the lower index on a tie.
  function automatic logic [2:0] pick_buffer(input logic [NT-1:0] pend, input logic [7:0] lpri [NT]);
    logic [7:0] best;
    logic [2:0] res;
    best = 8'hff;
    res  = 3'h0;
    for (int i = 0; i < NT; i++) begin
      if (pend[i] && (!res[2] || lpri[i] < best)) begin // [RULE10] [RULE23]
        best = lpri[i];
        res  = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(RX_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  can_buf_pkg::ctrl_s            ctrl_reg, ctrl_next;
  can_buf_pkg::tx_state_e        tx_state_reg, tx_state_next;
  logic [can_buf_pkg::TIMER_W-1:0] timer_reg, timer_next;
  tx_buf_t                       tx_mem_reg [NT];
  tx_buf_t                       tx_mem_next [NT];
  rx_buf_t                       rx_mem_reg [RX_DEPTH];
  rx_buf_t                       rx_mem_next [RX_DEPTH];
  rx_buf_t                       rx_bg_reg, rx_bg_next;
  logic [NT-1:0]                 empty_reg, empty_next;
  logic [NT-1:0]                 abort_req_reg, abort_req_next;
  logic [NT-1:0]                 abort_ack_reg, abort_ack_next;
  logic [NT-1:0]                 tx_irq_en_reg, tx_irq_en_next;
  logic [1:0]                    sel_idx_reg, sel_idx_next;
  logic                          sel_ok_reg, sel_ok_next;
  logic [1:0]                    cur_reg, cur_next;
  logic [PW-1:0]                 rd_ptr_reg, rd_ptr_next;
  logic [PW-1:0]                 wr_ptr_reg, wr_ptr_next;
  logic [PW:0]                   count_reg, count_next;
  logic                          rxf_reg, rxf_next;
  logic                          ovr_reg, ovr_next;
  logic [1:0]                    rx_irq_en_reg, rx_irq_en_next;
  logic [7:0]                    rdata_reg, rdata_next;
  logic [7:0]                    tx_byte_reg, tx_byte_next;
  logic                          tx_pending_reg, tx_pending_next;
  logic                          ack_en_reg, ack_en_next;
  logic                          tx_irq_reg, tx_irq_next;
  logic                          rx_irq_reg, rx_irq_next;
  logic                          ovr_irq_reg, ovr_irq_next;

  logic [7:0] lpri_vec [NT];
  logic [NT-1:0] pend;
  logic [2:0] pick;
  logic [3:0] tx_off;
  logic [3:0] rx_off;
  logic       tx_win_hit;
  logic       rx_win_hit;
  logic       own_frame;
  logic       pop;

  always_comb begin
    for (int i = 0; i < NT; i++) begin
      lpri_vec[i] = tx_mem_reg[i][can_buf_pkg::PRI_IDX];
    end
  end

  assign pend       = ~empty_reg;
  assign pick       = pick_buffer(pend, lpri_vec);
  assign tx_off     = 4'(reg_addr - can_buf_pkg::TX_WIN_ADDR);
  assign rx_off     = 4'(reg_addr - can_buf_pkg::RX_WIN_ADDR);
  assign tx_win_hit = reg_addr[7:4] == can_buf_pkg::TX_WIN_ADDR[7:4];
  assign rx_win_hit = (reg_addr[7:4] == can_buf_pkg::RX_WIN_ADDR[7:4]) &&
                      (rx_off < 4'(can_buf_pkg::RX_BUF_BYTES));
  // The sender's own frame is only a true reception in loopback.
  assign own_frame  = (tx_state_reg == can_buf_pkg::TX_ACTIVE) && !ctrl_reg.loopback; // [RULE20] [RULE21]
  assign pop        = reg_wr && (reg_addr == can_buf_pkg::RX_FLAG_ADDR) && reg_wdata[can_buf_pkg::FULL_BIT] &&
                      (count_reg != '0);

  always_comb begin
    ctrl_next      = ctrl_reg;
    tx_state_next  = tx_state_reg;
    timer_next     = timer_reg;
    tx_mem_next    = tx_mem_reg;
    rx_mem_next    = rx_mem_reg;
    rx_bg_next     = rx_bg_reg;
    empty_next     = empty_reg;
    abort_req_next = abort_req_reg;
    abort_ack_next = abort_ack_reg;
    tx_irq_en_next = tx_irq_en_reg;
    sel_idx_next   = sel_idx_reg;
    sel_ok_next    = sel_ok_reg;
    cur_next       = cur_reg;
    rd_ptr_next    = rd_ptr_reg;
    wr_ptr_next    = wr_ptr_reg;
    count_next     = count_reg;
    ovr_next       = ovr_reg;
    rx_irq_en_next = rx_irq_en_reg;
    rdata_next     = 8'h00;

    // Stamp timer.
    if (ctrl_reg.init_mode) begin
      timer_next = '0; // [RULE3]
    end else if (bit_tick) begin
      timer_next = timer_reg + can_buf_pkg::TIMER_W'(1); // [RULE2]
    end

    // Register writes: software clears come first so hardware sets below win.
    if (reg_wr) begin
      unique case (reg_addr)
        can_buf_pkg::CTRL_ADDR: ctrl_next = can_buf_pkg::ctrl_s'(reg_wdata);
        can_buf_pkg::TX_FLAG_ADDR: begin
          for (int i = 0; i < NT; i++) begin
            if (reg_wdata[i] && empty_reg[i]) begin
              empty_next[i]     = 1'b0; // [RULE8]
              abort_ack_next[i] = 1'b0; // [RULE13]
            end
          end
        end
        can_buf_pkg::TX_IRQ_EN_ADDR: tx_irq_en_next = reg_wdata[NT-1:0];
        can_buf_pkg::ABORT_REQ_ADDR: abort_req_next = reg_wdata[NT-1:0] & ~empty_reg; // [RULE12]
        can_buf_pkg::TX_SEL_ADDR: begin
          // The lowest requested buffer that is empty is mapped; none if none qualifies.
          sel_ok_next = 1'b0; // [RULE7]
          for (int i = NT - 1; i >= 0; i--) begin
            if (reg_wdata[i] && empty_reg[i]) begin
              sel_ok_next  = 1'b1;
              sel_idx_next = 2'(i);
            end
          end
        end
        can_buf_pkg::RX_FLAG_ADDR: begin
          if (reg_wdata[can_buf_pkg::OVR_BIT]) begin
            ovr_next = 1'b0;
          end
        end
        can_buf_pkg::RX_IRQ_EN_ADDR: rx_irq_en_next = reg_wdata[1:0];
        default: begin
          // The window only takes writes while the mapped buffer is still owned by software.
          if (tx_win_hit && sel_ok_reg && empty_reg[sel_idx_reg] && tx_off <= can_buf_pkg::PRI_IDX) begin
            tx_mem_next[sel_idx_reg][tx_off] = reg_wdata; // [RULE6] [RULE4]
          end
        end
      endcase
    end

    // Register reads answer in the following cycle only.
    if (reg_rd) begin
      unique case (reg_addr)
        can_buf_pkg::CTRL_ADDR:      rdata_next = ctrl_reg;
        can_buf_pkg::TX_FLAG_ADDR:   rdata_next = 8'(empty_reg);
        can_buf_pkg::TX_IRQ_EN_ADDR: rdata_next = 8'(tx_irq_en_reg);
        can_buf_pkg::ABORT_REQ_ADDR: rdata_next = 8'(abort_req_reg);
        can_buf_pkg::ABORT_ACK_ADDR: rdata_next = 8'(abort_ack_reg);
        can_buf_pkg::TX_SEL_ADDR:    rdata_next = sel_ok_reg ? 8'(1 << sel_idx_reg) : 8'h00;
        can_buf_pkg::RX_FLAG_ADDR:   rdata_next = {6'h00, ovr_reg, rxf_reg};
        can_buf_pkg::RX_IRQ_EN_ADDR: rdata_next = {6'h00, rx_irq_en_reg};
        default: begin
          if (tx_win_hit && sel_ok_reg && empty_reg[sel_idx_reg]) begin
            rdata_next = tx_mem_reg[sel_idx_reg][tx_off]; // [RULE4]
          end else if (rx_win_hit && count_reg != '0) begin
            rdata_next = rx_mem_reg[rd_ptr_reg][rx_off]; // [RULE14]
          end
        end
      endcase
    end

    // Abort grant: ack, empty and the interrupt are all set together on the same edge.
    for (int i = 0; i < NT; i++) begin
      if (abort_req_reg[i] && !empty_reg[i] &&
          !(tx_state_reg == can_buf_pkg::TX_ACTIVE && cur_reg == 2'(i))) begin // [RULE12]
        abort_ack_next[i] = 1'b1; // [RULE13]
        empty_next[i]     = 1'b1;
        abort_req_next[i] = 1'b0;
      end
    end

    // Transmit sequencing.
    unique case (tx_state_reg)
      can_buf_pkg::TX_IDLE: begin
        if (arb_start && pick[2] && !ctrl_reg.init_mode) begin
          tx_state_next = can_buf_pkg::TX_ACTIVE; // [RULE11]
          cur_next      = pick[1:0]; // [RULE5]
        end
      end
      can_buf_pkg::TX_ACTIVE: begin
        if (tx_done) begin
          tx_state_next     = can_buf_pkg::TX_IDLE;
          empty_next[cur_reg]     = 1'b1; // [RULE9]
          abort_ack_next[cur_reg] = 1'b0; // [RULE13]
          abort_req_next[cur_reg] = 1'b0;
          if (ctrl_reg.stamp_en) begin
            tx_mem_next[cur_reg][can_buf_pkg::TX_STAMP_HI] = timer_reg[15:8]; // [RULE1]
            tx_mem_next[cur_reg][can_buf_pkg::TX_STAMP_LO] = timer_reg[7:0];
          end
        end else if (tx_fail || ctrl_reg.init_mode) begin
          // An error or lost arbitration leaves the buffer queued for a fresh pick.
          tx_state_next = can_buf_pkg::TX_IDLE; // [RULE11] [RULE20]
        end
      end
    endcase

    // Background capture; stamp bytes belong to the device.
    if (rx_byte_valid && rx_byte_idx < 4'(can_buf_pkg::TX_MSG_BYTES)) begin
      rx_bg_next[rx_byte_idx] = rx_byte_data; // [RULE17] [RULE19] [RULE20]
    end

    if (pop) begin
      rd_ptr_next = ptr_inc(rd_ptr_reg); // [RULE18]
    end

    count_next = count_reg - (PW+1)'(pop);
    if (rx_frame_ok && rx_id_accept && !own_frame) begin
      if (count_reg == (PW+1)'(RX_DEPTH)) begin
        ovr_next = 1'b1; // [RULE22]
      end else begin
        rx_mem_next[wr_ptr_reg] = rx_bg_reg; // [RULE14] [RULE15]
        if (rx_byte_valid && rx_byte_idx < 4'(can_buf_pkg::TX_MSG_BYTES)) begin
          rx_mem_next[wr_ptr_reg][rx_byte_idx] = rx_byte_data;
        end
        if (ctrl_reg.stamp_en) begin
          rx_mem_next[wr_ptr_reg][can_buf_pkg::RX_STAMP_HI] = timer_reg[15:8]; // [RULE1]
          rx_mem_next[wr_ptr_reg][can_buf_pkg::RX_STAMP_LO] = timer_reg[7:0];
        end else begin
          rx_mem_next[wr_ptr_reg][can_buf_pkg::RX_STAMP_HI] = 8'h00;
          rx_mem_next[wr_ptr_reg][can_buf_pkg::RX_STAMP_LO] = 8'h00;
        end
        wr_ptr_next = ptr_inc(wr_ptr_reg);
        count_next  = count_reg - (PW+1)'(pop) + (PW+1)'(1); // [RULE17]
      end
    end

    // A push in the same cycle as a clear keeps the full flag up.
    rxf_next        = count_next != '0; // [RULE16] [RULE18]
    tx_byte_next    = tx_mem_reg[cur_reg][tx_byte_idx];
    tx_pending_next = |(~empty_next);
    ack_en_next     = !((tx_state_next == can_buf_pkg::TX_ACTIVE) && !ctrl_next.loopback); // [RULE20] [RULE21]
    tx_irq_next     = |(empty_next & tx_irq_en_next); // [RULE9] [RULE13]
    rx_irq_next     = rxf_next && rx_irq_en_next[can_buf_pkg::FULL_BIT]; // [RULE17]
    ovr_irq_next    = ovr_next && rx_irq_en_next[can_buf_pkg::OVR_BIT]; // [RULE22]
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_reg       <= can_buf_pkg::ctrl_s'(can_buf_pkg::CTRL_RESET);
      tx_state_reg   <= can_buf_pkg::TX_IDLE;
      timer_reg      <= '0;
      for (int i = 0; i < NT; i++) begin
        tx_mem_reg[i] <= '{default: 8'h00};
      end
      for (int i = 0; i < RX_DEPTH; i++) begin
        rx_mem_reg[i] <= '{default: 8'h00};
      end
      rx_bg_reg      <= '{default: 8'h00};
      empty_reg      <= '1;
      abort_req_reg  <= '0;
      abort_ack_reg  <= '0;
      tx_irq_en_reg  <= NT'(can_buf_pkg::TX_IRQ_EN_RESET);
      sel_idx_reg    <= 2'h0;
      sel_ok_reg     <= 1'b0;
      cur_reg        <= 2'h0;
      rd_ptr_reg     <= '0;
      wr_ptr_reg     <= '0;
      count_reg      <= '0;
      rxf_reg        <= 1'b0;
      ovr_reg        <= 1'b0;
      rx_irq_en_reg  <= 2'(can_buf_pkg::RX_IRQ_EN_RESET);
      rdata_reg      <= 8'h00;
      tx_byte_reg    <= 8'h00;
      tx_pending_reg <= 1'b0;
      ack_en_reg     <= 1'b1;
      tx_irq_reg     <= 1'b0;
      rx_irq_reg     <= 1'b0;
      ovr_irq_reg    <= 1'b0;
    end else begin
      ctrl_reg       <= ctrl_next;
      tx_state_reg   <= tx_state_next;
      timer_reg      <= timer_next;
      tx_mem_reg     <= tx_mem_next;
      rx_mem_reg     <= rx_mem_next;
      rx_bg_reg      <= rx_bg_next;
      empty_reg      <= empty_next;
      abort_req_reg  <= abort_req_next;
      abort_ack_reg  <= abort_ack_next;
      tx_irq_en_reg  <= tx_irq_en_next;
      sel_idx_reg    <= sel_idx_next;
      sel_ok_reg     <= sel_ok_next;
      cur_reg        <= cur_next;
      rd_ptr_reg     <= rd_ptr_next;
      wr_ptr_reg     <= wr_ptr_next;
      count_reg      <= count_next;
      rxf_reg        <= rxf_next;
      ovr_reg        <= ovr_next;
      rx_irq_en_reg  <= rx_irq_en_next;
      rdata_reg      <= rdata_next;
      tx_byte_reg    <= tx_byte_next;
      tx_pending_reg <= tx_pending_next;
      ack_en_reg     <= ack_en_next;
      tx_irq_reg     <= tx_irq_next;
      rx_irq_reg     <= rx_irq_next;
      ovr_irq_reg    <= ovr_irq_next;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign tx_byte       = tx_byte_reg;
  assign tx_buf_idx    = cur_reg;
  assign tx_pending    = tx_pending_reg;
  assign tx_busy       = tx_state_reg == can_buf_pkg::TX_ACTIVE;
  assign rx_ack_enable = ack_en_reg;
  assign tx_irq        = tx_irq_reg;
  assign rx_irq        = rx_irq_reg;
  assign ovr_irq       = ovr_irq_reg;

endmodule

`default_nettype wire

// File: bench/can_buf_monitor.sv
// Port-level checker for the CAN message buffer manager, bound to the design top.
`timescale 1ns/1ns
`default_nettype none
module can_buf_monitor (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       arb_start,
  input wire logic       tx_done,
  input wire logic       tx_fail,
  input wire logic [1:0] tx_buf_idx,
  input wire logic       tx_pending,
  input wire logic       tx_busy,
  input wire logic       rx_frame_ok,
  input wire logic       rx_id_accept,
  input wire logic       rx_ack_enable,
  input wire logic       tx_irq,
  input wire logic       rx_irq,
  input wire logic       ovr_irq
);
  // Shadows of control and enables, because only the ports are visible here.
  logic [7:0] ctl_reg, ten_reg, ren_reg;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_reg <= can_buf_pkg::CTRL_RESET;
      ten_reg <= 8'h00;
      ren_reg <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == can_buf_pkg::CTRL_ADDR) ctl_reg <= reg_wdata;
      if (reg_addr == can_buf_pkg::TX_IRQ_EN_ADDR) ten_reg <= reg_wdata;
      if (reg_addr == can_buf_pkg::RX_IRQ_EN_ADDR) ren_reg <= reg_wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_arb_takes: assert property (arb_start && !tx_busy && tx_pending && !ctl_reg[0] |=> tx_busy)
    else $error("arbitration ignored");
  a_busy_holds: assert property (tx_busy && !tx_done && !tx_fail && !ctl_reg[0] |=> tx_busy)
    else $error("busy dropped");
  a_end_frees: assert property (tx_busy && (tx_done || tx_fail) |=> !tx_busy)
    else $error("busy after end");
  a_txirq_lag: assert property (tx_busy && tx_done && ten_reg[tx_buf_idx] |-> ##2 tx_irq)
    else $error("no tx interrupt");
  a_init_idle: assert property (ctl_reg[0] && $past(ctl_reg[0]) |-> !tx_busy)
    else $error("busy in init");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("stray read data");
  a_ack_idle: assert property (!tx_busy && !$past(tx_busy) |-> rx_ack_enable)
    else $error("ack withheld");
  a_rx_push: assert property (rx_frame_ok && rx_id_accept && (!tx_busy || ctl_reg[1]) && ren_reg[0]
    |-> ##[1:2] rx_irq)
    else $error("no rx interrupt");
  a_ovr_holds: assert property (ovr_irq && !reg_wr |=> ovr_irq)
    else $error("overrun dropped");
  c_sent: cover property (tx_busy && tx_done);
  c_retry: cover property (tx_busy && tx_fail);
  c_overrun: cover property ($rose(ovr_irq));
endmodule
bind can_message_buffer_manager can_buf_monitor can_buf_monitor_i (.*);
`default_nettype wire

// File: bench/can_bus_node.sv
// Behavioural protocol engine and remote nodes that face the buffer manager.
`timescale 1ns/1ns
`default_nettype none
module can_bus_node (
  input  wire logic       clk,
  output logic            bit_tick = 1'b0,
  output logic            arb_start = 1'b0,
  output logic            tx_done = 1'b0,
  output logic            tx_fail = 1'b0,
  output logic      [3:0] tx_byte_idx = 4'h0,
  output logic            rx_byte_valid = 1'b0,
  output logic      [3:0] rx_byte_idx = 4'h0,
  output logic      [7:0] rx_byte_data = 8'h00,
  output logic            rx_frame_ok = 1'b0,
  output logic            rx_id_accept = 1'b0
);
  logic [1:0] div = 2'h0;
  // The bit clock runs free, so the stamp timer also moves between frames.
  always @(posedge clk) begin
    div <= div + 2'h1;
    bit_tick <= (div == 2'h3);
  end
  task automatic arb();
    arb_start <= 1'b1;
    @(posedge clk);
    arb_start <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fetch(input logic [3:0] i);
    tx_byte_idx <= i;
    repeat (2) @(posedge clk);
  endtask
  task automatic finish(input logic ok, input logic [2:0] gap);
    repeat (gap) @(posedge clk);
    tx_done <= ok;
    tx_fail <= !ok;
    @(posedge clk);
    tx_done <= 1'b0;
    tx_fail <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] seed, input logic ok, input logic acc);
    for (int i = 0; i < 13; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte_idx <= i[3:0];
      rx_byte_data <= seed + i[7:0];
      @(posedge clk);
    end
    // Released data lines show a changed value so stale bytes cannot pass.
    rx_byte_valid <= 1'b0;
    rx_byte_data <= ~rx_byte_data;
    rx_frame_ok <= ok;
    rx_id_accept <= acc;
    @(posedge clk);
    rx_frame_ok <= 1'b0;
    rx_id_accept <= !acc;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/can_message_buffer_manager_test.sv
// Self-checking regression for the CAN message buffer manager.
`timescale 1ns/1ns
`default_nettype none
module can_message_buffer_manager_test;
  localparam logic [7:0] CTL = can_buf_pkg::CTRL_ADDR, TXF = can_buf_pkg::TX_FLAG_ADDR;
  localparam logic [7:0] TEN = can_buf_pkg::TX_IRQ_EN_ADDR, SEL = can_buf_pkg::TX_SEL_ADDR;
  localparam logic [7:0] RFL = can_buf_pkg::RX_FLAG_ADDR, REN = can_buf_pkg::RX_IRQ_EN_ADDR;
  localparam logic [7:0] TXW = can_buf_pkg::TX_WIN_ADDR, RXW = can_buf_pkg::RX_WIN_ADDR;
  localparam logic [7:0] PRI = TXW + 8'(can_buf_pkg::PRI_IDX), RSH = RXW + 8'(can_buf_pkg::RX_STAMP_HI);
  localparam logic [7:0] SHI = TXW + 8'(can_buf_pkg::TX_STAMP_HI), SLO = TXW + 8'(can_buf_pkg::TX_STAMP_LO);
  logic        clk, nrst, reg_wr, reg_rd, init_m;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, tx_byte;
  logic [1:0]  tx_buf_idx;
  logic        tx_pending, tx_busy, rx_ack_enable, tx_irq, rx_irq, ovr_irq;
  logic        bit_tick, arb_start, tx_done, tx_fail, rx_byte_valid, rx_frame_ok, rx_id_accept;
  logic [3:0]  tx_byte_idx, rx_byte_idx;
  logic [7:0]  rx_byte_data;
  logic [15:0] tick_cnt, exp_stamp;
  logic [31:0] rnd;
  logic [7:0]  lpri [3];
  logic [7:0]  msg [3];
  logic [7:0]  q [$];
  logic [2:0]  p;
  int          err_count, total_checks;
  can_message_buffer_manager #(.RX_DEPTH(5)) can_message_buffer_manager_i (.*);
  can_bus_node can_bus_node_i (.*);
  always #50 clk = ~clk;
  // Mirror of the stamp timer, captured at the acknowledge edge.
  always @(posedge clk) begin
    if (!nrst || init_m) tick_cnt <= 16'h0000;
    else tick_cnt <= tick_cnt + {15'h0000, bit_tick};
    if (!nrst) init_m <= 1'b1;
    else if (reg_wr && reg_addr == CTL) init_m <= reg_wdata[0];
    if (tx_done && tx_busy) exp_stamp <= tick_cnt;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [1:0] pick(input logic [2:0] pend);
    logic [1:0] b;
    b = 2'h3;
    for (int i = 2; i >= 0; i--)
      if (pend[i] && (b == 2'h3 || lpri[i] <= lpri[b])) b = i[1:0];
    return b;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic load(input int b, input logic [7:0] pr);
    rnd = lfsr(rnd);
    msg[b] = rnd[7:0];
    lpri[b] = pr;
    wr(SEL, 8'h01 << b);
    rchk(SEL, 8'h01 << b);
    for (int i = 0; i < 13; i++) wr(TXW + i[7:0], msg[b] + i[7:0]);
    wr(PRI, pr);
    wr(TXF, 8'h01 << b);
  endtask
  task automatic send_one(input logic fail_first);
    logic [1:0] k;
    k = pick(p);
    if (fail_first) begin
      can_bus_node_i.arb();
      can_bus_node_i.finish(1'b0, 3'h0);
    end
    can_bus_node_i.arb();
    chk({6'h00, tx_buf_idx}, {6'h00, k});
    can_bus_node_i.fetch(4'h0);
    chk(tx_byte, msg[k]);
    can_bus_node_i.fetch(can_buf_pkg::PRI_IDX);
    chk(tx_byte, lpri[k]);
    can_bus_node_i.finish(1'b1, rnd[2:0]);
    p = p & ~(3'h1 << k);
    rchk(TXF, {5'h00, ~p});
    wr(SEL, 8'h01 << k);
    wr(SHI, ~exp_stamp[15:8]);
    rchk(SHI, exp_stamp[15:8]);
    rchk(SLO, exp_stamp[7:0]);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("MISMATCH at %0t: run did not complete", $time);
    tally_and_finish();
  end
  initial begin
    {clk, nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {err_count, total_checks} = '0;
    rnd = 32'h509bdadd;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rchk(CTL, can_buf_pkg::CTRL_RESET);
    rchk(TXF, 8'h07);
    rchk(TEN, can_buf_pkg::TX_IRQ_EN_RESET);
    rchk(REN, can_buf_pkg::RX_IRQ_EN_RESET);
    rchk(8'h3f, 8'h00);
    $display("test reset values done");
    wr(TEN, 8'h07);
    for (int r = 0; r < 4; r++) begin
      // Passing through initialization clears the timer before each round.
      wr(CTL, 8'h05);
      wr(CTL, 8'h04);
      for (int b = 0; b < 3; b++) load(b, (r == 3) ? 8'h40 : rnd[15:8]);
      p = 3'h7;
      repeat (3) send_one(r[0]);
      $display("test transmit round %0d done", r);
    end
    chk({6'h00, tx_pending, tx_irq}, 8'h01);
    load(0, 8'h01);
    load(1, 8'h02);
    wr(TEN, 8'h02);
    chk({6'h00, tx_pending, tx_irq}, 8'h02);
    can_bus_node_i.arb();
    wr(can_buf_pkg::ABORT_REQ_ADDR, 8'h03);
    rchk(can_buf_pkg::ABORT_ACK_ADDR, 8'h02);
    rchk(TXF, 8'h06);
    chk({6'h00, tx_irq, tx_busy}, 8'h03);
    can_bus_node_i.finish(1'b1, 3'h2);
    rchk(can_buf_pkg::ABORT_ACK_ADDR, 8'h02);
    rchk(TXF, 8'h07);
    $display("test abort done");
    wr(CTL, 8'h00);
    wr(REN, 8'h03);
    can_bus_node_i.frame(8'h80, 1'b1, 1'b0);
    can_bus_node_i.frame(8'h90, 1'b0, 1'b1);
    chk({7'h00, rx_irq}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      if (i < 5) q.push_back(rnd[7:0]);
      can_bus_node_i.frame(rnd[7:0], 1'b1, 1'b1);
    end
    chk({6'h00, ovr_irq, rx_irq}, 8'h03);
    rchk(RFL, 8'h03);
    while (q.size() > 0) begin
      rchk(RXW, q[0]);
      rchk(RXW + 8'h0c, q[0] + 8'h0c);
      rchk(RSH, 8'h00);
      void'(q.pop_front());
      wr(RFL, 8'h01);
    end
    rchk(RFL, 8'h02);
    wr(RFL, 8'h02);
    $display("test receive fifo done");
    for (int m = 0; m < 2; m++) begin
      wr(CTL, {6'h00, m[0], 1'b0});
      load(0, 8'h10);
      can_bus_node_i.arb();
      chk({7'h00, rx_ack_enable}, {7'h00, m[0]});
      can_bus_node_i.frame(8'h44, 1'b1, 1'b1);
      can_bus_node_i.finish(1'b1, 3'h0);
      rchk(RFL, {7'h00, m[0]});
    end
    rchk(RXW, 8'h44);
    $display("test own frames done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
